//--- core/dmasup_pkg.sv
// constants shared by the dma support logic
`default_nettype none
package dmasup_pkg;
   // ***********************************************
   // timing control register fields
   // ***********************************************
   localparam int unsigned  EARLY_RD_BIT     = 0;
   localparam int unsigned  WAIT_W           = 4;
   localparam logic [3:0]   WAIT8_RESET      = 4'h1;
   localparam logic [3:0]   WAIT16_RESET     = 4'h1;
   localparam logic         EARLY_RD_RESET   = 1'h0;
   // ***********************************************
   // address layout
   // ***********************************************
   localparam int unsigned  PAGE_W           = 10;
   localparam int unsigned  MEM_ADDR_W       = 26;
   localparam int unsigned  CHAN_N           = 8;
   localparam logic [7:0]   CASCADE_HOST_CH  = 8'h10;
   // ***********************************************
   // hold arbiter states
   // ***********************************************
   typedef enum logic [2:0] {
      ARB_IDLE    = 3'b001,
      ARB_DMA     = 3'b010,
      ARB_REFRESH = 3'b100
   } dmasup_arb_t;
endpackage
`default_nettype wire

//--- core/dmasup_ready.sv
// ready generation shared by both dma controller cores
`timescale 1ns/1ps
`default_nettype none
module dmasup_ready #(
   parameter int unsigned WAIT_W = 4
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic              cycle_start,
   input  wire logic              cycle_active,
   input  wire logic [WAIT_W-1:0] wait_count,
   input  wire logic              io_channel_ready,
   output logic                   ready_out
);
   logic [WAIT_W-1:0] cnt_q;
   logic [WAIT_W-1:0] cnt_d;
   logic              done_w;

   // ***********************************************
   // forced waits then slot ready stretch
   // ***********************************************
   assign done_w = (cnt_q == '0);
   // slot ready gates the output directly, unregistered, so a late return costs no extra wait
   assign cnt_d  = cycle_start ? wait_count : (done_w ? cnt_q : cnt_q - 1'b1);
   assign ready_out = cycle_active && !cycle_start && done_w
                      && io_channel_ready;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule
`default_nettype wire

//--- core/dmasup_top.sv
// dma support: address map, ready, cascade release, hold arbiter, read delay
`timescale 1ns/1ps
`default_nettype none
//
// Behaviour
// - 8-bit: page, latched data, core address
// - 16-bit: page bit 0 dropped, latched data and core address shifted left one
// - both cores share one ready source
// - forced waits each transfer, reset one
// - software sets wait counts after reset
// - ready low keeps inserting wait states
// - late ready return passes straight through, no added wait
// - acknowledged cascade channel releases buses
// - arbiter: controller hold, refresh rising edge
// - hand over without dropping cpu hold
// - drop hold when nobody requests, or at refresh end with only a refresh edge pending
// - read strobe fall delayed one clock
// - read strobe rise not delayed
// - early select bit removes read delay
module dmasup_top #(
   parameter int unsigned PAGE_W = dmasup_pkg::PAGE_W,
   parameter int unsigned CHAN_N = dmasup_pkg::CHAN_N
) (
   input  wire logic                        ref_clk,
   input  wire logic                        rst_n,
   input  wire logic                        cfg_wr,
   input  wire logic [7:0]                  cfg_wdata,
   input  wire logic                        cfg_sel16,
   output logic [7:0]                       dma_timing_control_reg,
   input  wire logic                        xfer16,
   input  wire logic [PAGE_W-1:0]           page_latch,
   input  wire logic [7:0]                  ctrl_data_latch,
   input  wire logic [7:0]                  ctrl_addr,
   input  wire logic                        onboard_mem,
   output logic [dmasup_pkg::MEM_ADDR_W-1:0] mem_addr,
   output logic [3:0]                       byte_en_n,
   input  wire logic                        cycle_start,
   input  wire logic                        cycle_active,
   input  wire logic                        io_channel_ready,
   output logic                             ctrl_ready,
   input  wire logic [CHAN_N-1:0]           chan_cascade,
   input  wire logic [CHAN_N-1:0]           chan_ack,
   output logic                             bus_drive_en,
   input  wire logic                        dma_ctrl2_hold_request,
   input  wire logic                        refresh_timer_out,
   input  wire logic                        refresh_done,
   input  wire logic                        hold_acknowledge_in,
   output logic                             hold_request_out,
   output logic                             dma_hold_ack,
   output logic                             refresh_ack,
   input  wire logic                        core_mem_read_n,
   output logic                             mem_read_n
);
   // ***********************************************
   // timing control register
   // ***********************************************
   logic [dmasup_pkg::WAIT_W-1:0] wait8_q;
   logic [dmasup_pkg::WAIT_W-1:0] wait16_q;
   logic                          early_q;
   logic [dmasup_pkg::WAIT_W-1:0] wait_sel_w;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wait8_q  <= dmasup_pkg::WAIT8_RESET;
         wait16_q <= dmasup_pkg::WAIT16_RESET;
         early_q  <= dmasup_pkg::EARLY_RD_RESET;
      end else if (cfg_wr) begin
         // upper nibble is the wait count of the selected width
         if (cfg_sel16) begin
            wait16_q <= cfg_wdata[7:4];
         end else begin
            wait8_q <= cfg_wdata[7:4];
         end
         early_q <= cfg_wdata[dmasup_pkg::EARLY_RD_BIT];
      end
   end
   assign dma_timing_control_reg = {(cfg_sel16 ? wait16_q : wait8_q), 3'h0, early_q};
   assign wait_sel_w = xfer16 ? wait16_q : wait8_q;

   // ***********************************************
   // address and byte enables
   // ***********************************************
   logic [dmasup_pkg::MEM_ADDR_W-1:0] addr8_w;
   logic [dmasup_pkg::MEM_ADDR_W-1:0] addr16_w;
   logic [3:0]                        be8_w;
   logic [3:0]                        be16_w;

   assign addr8_w  = {page_latch, ctrl_data_latch, ctrl_addr};
   assign addr16_w = {page_latch[PAGE_W-1:1], ctrl_data_latch, ctrl_addr, 1'b0};

   function automatic logic [3:0] be_decode(input logic [1:0] a);
      be_decode = ~(4'h1 << a);
   endfunction
   assign be8_w  = be_decode(ctrl_addr[1:0]);
   assign be16_w = ctrl_addr[0] ? 4'h3 : 4'hc;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_addr  <= '0;
         byte_en_n <= 4'hf;
      end else begin
         mem_addr  <= xfer16 ? addr16_w : addr8_w;
         byte_en_n <= !onboard_mem ? 4'hf : (xfer16 ? be16_w : be8_w);
      end
   end

   // ***********************************************
   // ready, one source for both cores
   // ***********************************************
   dmasup_ready #(
      .WAIT_W (dmasup_pkg::WAIT_W)
   ) u_ready (
      .ref_clk          (ref_clk),
      .rst_n            (rst_n),
      .cycle_start      (cycle_start),
      .cycle_active     (cycle_active),
      .wait_count       (wait_sel_w),
      .io_channel_ready (io_channel_ready),
      .ready_out        (ctrl_ready)
   );

   // ***********************************************
   // cascade release
   // ***********************************************
   // release follows the acknowledge combinationally, no gap for contention
   assign bus_drive_en = ~|(chan_cascade & chan_ack);

   // ***********************************************
   // hold arbiter
   // ***********************************************
   dmasup_pkg::dmasup_arb_t arb_q;
   dmasup_pkg::dmasup_arb_t arb_d;
   logic                    tmr_q;
   logic                    ref_pend_q;
   logic                    ref_rise_w;

   assign ref_rise_w = refresh_timer_out && !tmr_q;

   always_comb begin
      arb_d = arb_q;
      case (arb_q)
         dmasup_pkg::ARB_IDLE: begin
            if (ref_pend_q || ref_rise_w) begin
               arb_d = dmasup_pkg::ARB_REFRESH;
            end else if (dma_ctrl2_hold_request) begin
               arb_d = dmasup_pkg::ARB_DMA;
            end
         end
         dmasup_pkg::ARB_DMA: begin
            if (!dma_ctrl2_hold_request) begin
               // an edge in the same cycle must not let hold drop for one clock
               arb_d = (ref_pend_q || ref_rise_w) ? dmasup_pkg::ARB_REFRESH
                                                  : dmasup_pkg::ARB_IDLE;
            end
         end
         dmasup_pkg::ARB_REFRESH: begin
            if (refresh_done) begin
               arb_d = dma_ctrl2_hold_request ? dmasup_pkg::ARB_DMA
                                              : dmasup_pkg::ARB_IDLE;
            end
         end
         default: arb_d = dmasup_pkg::ARB_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         arb_q      <= dmasup_pkg::ARB_IDLE;
         tmr_q      <= 1'b0;
         ref_pend_q <= 1'b0;
      end else begin
         arb_q <= arb_d;
         tmr_q <= refresh_timer_out;
         // entering refresh consumes the request; a later edge waits for the next round
         if (arb_d == dmasup_pkg::ARB_REFRESH && arb_q != dmasup_pkg::ARB_REFRESH) begin
            ref_pend_q <= 1'b0;
         end else if (ref_rise_w) begin
            ref_pend_q <= 1'b1;
         end
      end
   end

   // hold stays up across the handover since idle is skipped
   assign hold_request_out = (arb_q != dmasup_pkg::ARB_IDLE);
   assign dma_hold_ack = hold_acknowledge_in && (arb_q == dmasup_pkg::ARB_DMA);
   assign refresh_ack  = hold_acknowledge_in && (arb_q == dmasup_pkg::ARB_REFRESH);

   // ***********************************************
   // memory read strobe delay
   // ***********************************************
   logic core_rd_q;
   logic mem_read_n_q;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         core_rd_q    <= 1'b1;
         mem_read_n_q <= 1'b1;
      end else begin
         core_rd_q <= core_mem_read_n;
         // fall one clock late unless early select; rise tracks the core
         mem_read_n_q <= core_mem_read_n
                         | (!early_q & core_rd_q);
      end
   end
   assign mem_read_n = mem_read_n_q;
endmodule
`default_nettype wire

//--- test/dmasup_sva.sv
// port assertions for the dma support block
`timescale 1ns/1ps
`default_nettype none
module dmasup_sva #(
   parameter int unsigned PAGE_W = 10,
   parameter int unsigned CHAN_N = 8
) (
   input wire logic              ref_clk,
   input wire logic              rst_n,
   input wire logic [7:0]        dma_timing_control_reg,
   input wire logic              xfer16,
   input wire logic [PAGE_W-1:0] page_latch,
   input wire logic [7:0]        ctrl_data_latch,
   input wire logic [7:0]        ctrl_addr,
   input wire logic              onboard_mem,
   input wire logic [25:0]       mem_addr,
   input wire logic [3:0]        byte_en_n,
   input wire logic              io_channel_ready,
   input wire logic              ctrl_ready,
   input wire logic [CHAN_N-1:0] chan_cascade,
   input wire logic [CHAN_N-1:0] chan_ack,
   input wire logic              bus_drive_en,
   input wire logic              dma_ctrl2_hold_request,
   input wire logic              hold_request_out,
   input wire logic              core_mem_read_n,
   input wire logic              mem_read_n
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   property p_a8; onboard_mem && !xfer16 |=> mem_addr ==
      {$past(page_latch), $past(ctrl_data_latch), $past(ctrl_addr)}; endproperty
   a_a8: assert property (p_a8) else $error("8-bit address wrong");
   property p_a16; onboard_mem && xfer16 |=> mem_addr ==
      {$past(page_latch[PAGE_W-1:1]), $past(ctrl_data_latch), $past(ctrl_addr), 1'b0};
   endproperty
   a_a16: assert property (p_a16) else $error("16-bit address wrong");
   property p_be8; onboard_mem && !xfer16 |=>
      byte_en_n == ~(4'h1 << $past(ctrl_addr[1:0])); endproperty
   a_be8: assert property (p_be8) else $error("byte enable wrong");
   property p_slot; !io_channel_ready |-> !ctrl_ready; endproperty
   a_slot: assert property (p_slot) else $error("ready while slot busy");
   property p_rel; bus_drive_en == !(|(chan_ack & chan_cascade)); endproperty
   a_rel: assert property (p_rel) else $error("bus drive wrong");
   property p_hold; dma_ctrl2_hold_request |=> hold_request_out; endproperty
   a_hold: assert property (p_hold) else $error("hold not raised");
   property p_fall; $fell(core_mem_read_n) && !dma_timing_control_reg[0] ##1 !core_mem_read_n
      |-> mem_read_n ##1 !mem_read_n; endproperty
   a_fall: assert property (p_fall) else $error("read fall not delayed");
   property p_early; $fell(core_mem_read_n) && dma_timing_control_reg[0] |=> !mem_read_n;
   endproperty
   a_early: assert property (p_early) else $error("early read late");
   property p_rise; $rose(core_mem_read_n) |=> mem_read_n; endproperty
   a_rise: assert property (p_rise) else $error("read rise delayed");
endmodule
`default_nettype wire

//--- test/dmasup_cpu_model.sv
// cpu side of the hold handshake, prompt or slow
`timescale 1ns/1ps
`default_nettype none
module dmasup_cpu_model (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic slow,
   input  wire logic hold_request_out,
   output logic      hold_acknowledge_in
);
   logic [2:0] cnt_q;
   // grant after 1 or 4 cycles; withdraws at once so no stale grant lingers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) cnt_q <= 3'h0;
      else if (!hold_request_out) cnt_q <= 3'h0;
      else if (cnt_q != 3'h4) cnt_q <= cnt_q + 3'h1;
   end
   assign hold_acknowledge_in = hold_request_out && (cnt_q >= (slow ? 3'h4 : 3'h1));
endmodule
`default_nettype wire

//--- test/test_dmasup_top.sv
// self-checking bench for the dma support block
`timescale 1ns/1ps
`default_nettype none
module test_dmasup_top;
   logic ref_clk = 0, rst_n = 0, cfg_wr = 0, cfg_sel16 = 0, xfer16 = 0, onboard_mem = 0;
   logic cycle_start = 0, cycle_active = 0, io_channel_ready = 1, refresh_done = 0, slow = 0;
   logic dma_ctrl2_hold_request = 0, refresh_timer_out = 0, core_mem_read_n = 1;
   logic ctrl_ready, bus_drive_en, hold_request_out, dma_hold_ack, refresh_ack;
   logic hold_acknowledge_in, mem_read_n;
   logic [7:0] cfg_wdata = 0, ctrl_data_latch = 0, ctrl_addr = 0, chan_cascade = 0, chan_ack = 0;
   logic [7:0] dma_timing_control_reg;
   logic [9:0] page_latch = 0;
   logic [25:0] mem_addr;
   logic [3:0] byte_en_n;
   int n_fail = 0, num_checks = 0, cyc = 0, k;
   dmasup_top u_dmasup_top (
      .ref_clk(ref_clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
      .cfg_sel16(cfg_sel16), .dma_timing_control_reg(dma_timing_control_reg),
      .xfer16(xfer16), .page_latch(page_latch), .ctrl_data_latch(ctrl_data_latch),
      .ctrl_addr(ctrl_addr), .onboard_mem(onboard_mem), .mem_addr(mem_addr),
      .byte_en_n(byte_en_n), .cycle_start(cycle_start), .cycle_active(cycle_active),
      .io_channel_ready(io_channel_ready), .ctrl_ready(ctrl_ready),
      .chan_cascade(chan_cascade), .chan_ack(chan_ack), .bus_drive_en(bus_drive_en),
      .dma_ctrl2_hold_request(dma_ctrl2_hold_request),
      .refresh_timer_out(refresh_timer_out), .refresh_done(refresh_done),
      .hold_acknowledge_in(hold_acknowledge_in), .hold_request_out(hold_request_out),
      .dma_hold_ack(dma_hold_ack), .refresh_ack(refresh_ack),
      .core_mem_read_n(core_mem_read_n), .mem_read_n(mem_read_n)
   );
   dmasup_cpu_model u_dmasup_cpu_model (
      .ref_clk(ref_clk), .rst_n(rst_n), .slow(slow), .hold_request_out(hold_request_out),
      .hold_acknowledge_in(hold_acknowledge_in)
   );
   always #12.5 ref_clk = ~ref_clk;
   // ceiling far above the fewer than two hundred cycles the sequence needs
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 4000) begin
         n_fail++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   function automatic logic pick(input int w);
      return w == 0 ? ctrl_ready : w == 1 ? mem_read_n : dma_hold_ack;
   endfunction
   // counts falling edges until the chosen output reaches lvl
   task automatic wt(input int w, input logic lvl);
      k = 0;
      do begin
         @(negedge ref_clk);
         k++;
      end while (pick(w) !== lvl && k < 40);
   endtask
   task automatic cfgw(input logic s, input logic [7:0] d);
      @(posedge ref_clk) {cfg_wr, cfg_sel16, cfg_wdata} <= {1'b1, s, d};
      @(posedge ref_clk) cfg_wr <= 0;
      @(negedge ref_clk) chk(dma_timing_control_reg, {d[7:4], 3'h0, d[0]});
   endtask
   task automatic t_addr();
      logic [25:0] e;
      for (int i = 0; i < 10; i++) begin
         @(posedge ref_clk) {onboard_mem, xfer16} <= {i < 8, i[0]};
         {page_latch, ctrl_data_latch, ctrl_addr} <= {10'h2b5 ^ i[9:0], 8'h5a ^ i[7:0], 6'h29, i[2:1]};
         @(posedge ref_clk);
         @(negedge ref_clk);
         e = xfer16 ? {page_latch[9:1], ctrl_data_latch, ctrl_addr, 1'b0}
                    : {page_latch, ctrl_data_latch, ctrl_addr};
         if (onboard_mem) chk(mem_addr, e);
         chk(byte_en_n, !onboard_mem ? 4'hf : xfer16 ? (ctrl_addr[0] ? 4'h3 : 4'hc)
                        : 4'(~(4'h1 << ctrl_addr[1:0])));
      end
   endtask
   task automatic t_ready(input logic x, input int n, input int stall);
      @(posedge ref_clk) {xfer16, cycle_start, cycle_active, io_channel_ready} <= {x, 2'b11, stall == 0};
      fork
         begin
            @(posedge ref_clk) cycle_start <= 0;
            repeat (stall) @(posedge ref_clk);
            io_channel_ready <= 1;
         end
         wt(0, 1);
      join
      if (stall == 0) chk(k, n + 2);
      else chk(k > stall + 1 && k < stall + 4, 1);
      @(posedge ref_clk) cycle_active <= 0;
   endtask
   task automatic t_casc();
      for (int i = 0; i < 16; i++) begin
         @(posedge ref_clk) chan_cascade <= 8'h1 << i[2:0];
         chan_ack <= 8'h1 << (i[2:0] + i[3]);
         @(negedge ref_clk) chk(bus_drive_en, i[3]);
      end
      @(posedge ref_clk) chan_ack <= 0;
   endtask
   task automatic t_hold(input logic s);
      @(posedge ref_clk) {slow, dma_ctrl2_hold_request} <= {s, 1'b1};
      wt(2, 1);
      chk(k < 8, 1);
      @(posedge ref_clk) refresh_timer_out <= 1;
      @(posedge ref_clk) dma_ctrl2_hold_request <= 0;
      k = 0;
      do begin
         @(negedge ref_clk);
         k++;
         chk(hold_request_out, 1);
      end while (refresh_ack !== 1 && k < 10);
      chk({refresh_ack, dma_hold_ack}, 2'b10);
      @(posedge ref_clk) {refresh_done, refresh_timer_out} <= 2'b10;
      @(posedge ref_clk) refresh_done <= 0;
      @(negedge ref_clk) chk(hold_request_out, 0);
   endtask
   task automatic t_memr(input logic e);
      cfgw(0, {7'h18, e});
      @(posedge ref_clk) core_mem_read_n <= 0;
      wt(1, 0);
      chk(k, 3 - e);
      @(posedge ref_clk) core_mem_read_n <= 1;
      wt(1, 1);
      chk(k, 2);
   endtask
   initial begin
      repeat (12) @(posedge ref_clk);
      rst_n <= 1;
      @(negedge ref_clk) chk(dma_timing_control_reg, 8'h10);
      @(posedge ref_clk) cfg_sel16 <= 1;
      @(negedge ref_clk) chk(dma_timing_control_reg, 8'h10);
      t_addr();
      t_ready(0, 1, 0);
      t_ready(1, 1, 0);
      cfgw(0, 8'h30);
      t_ready(0, 3, 0);
      t_ready(1, 1, 0);
      t_ready(0, 3, 5);
      cfgw(1, 8'h20);
      t_ready(1, 2, 0);
      t_casc();
      t_hold(0);
      t_hold(1);
      t_memr(0);
      t_memr(1);
      stop_test();
   end
endmodule
bind dmasup_top dmasup_sva #(.PAGE_W(PAGE_W), .CHAN_N(CHAN_N)) u_dmasup_sva (
   .ref_clk(ref_clk), .rst_n(rst_n), .dma_timing_control_reg(dma_timing_control_reg),
   .xfer16(xfer16), .page_latch(page_latch), .ctrl_data_latch(ctrl_data_latch),
   .ctrl_addr(ctrl_addr), .onboard_mem(onboard_mem), .mem_addr(mem_addr),
   .byte_en_n(byte_en_n), .io_channel_ready(io_channel_ready), .ctrl_ready(ctrl_ready),
   .chan_cascade(chan_cascade), .chan_ack(chan_ack), .bus_drive_en(bus_drive_en),
   .dma_ctrl2_hold_request(dma_ctrl2_hold_request), .hold_request_out(hold_request_out),
   .core_mem_read_n(core_mem_read_n), .mem_read_n(mem_read_n)
);
`default_nettype wire
